// ---- hw/udwcs_host.sv ----
// Purpose: Host controller driving select, step and direction of a stepped wiper device
// Assumes: Single 100 MHz clock, synchronous active high reset
// Notes: Tracks the wiper position as a saturating model of the device counter
//
// How it works
// - After save deselect, host holds select high at least 10 ms
// - After plain deselect, host holds select high at least 100 ns
// - Host waits 100 ns after step rises before changing direction, except after a no-save release, where 10 ns can pass
// - Host waits 1 us from step inactive to releasing select
// - Host holds select and step high from reset until the first frame drives them low
// - Releasing select with step low deselects without a save
module udwcs_host (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire udwcs_pkg::udwcs_req_t req,
    input wire logic [6:0] start_pos,
    input wire logic start_load,
    output logic req_ready,
    output logic busy,
    output logic [6:0] pos,
    output udwcs_pkg::udwcs_pins_t pins
);
    import udwcs_pkg::*;

    udwcs_state_t state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [6:0] left_reg;
    logic save_reg;
    logic up_reg;

    function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
        return CNT_W'(n - 1);
    endfunction

    // Release and guard cycles in which a no-save frame leaves step where it is
    function automatic logic tail_hold(input udwcs_state_t s, input logic [CNT_W-1:0] c);
        return s == ST_PRE || s == ST_DESEL || (s == ST_GUARD && c != '0);
    endfunction

    // Cycle in which the sequence hands control back to the user
    function automatic logic is_done(input udwcs_state_t s, input logic [CNT_W-1:0] c,
        input logic v);
        return (s == ST_GUARD && c == '0) || (s == ST_IDLE && !v) ||
            (s == ST_WAKE && c == '0);
    endfunction

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_WAKE;
            cnt_reg <= cyc(POWERUP_CYC);
            left_reg <= 7'h00;
            save_reg <= 1'b0;
            up_reg <= 1'b0;
        end else begin
            case (state_reg)
                // Let the device recall its stored tap before any command
                ST_WAKE: begin
                    if (cnt_reg == '0) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_IDLE: begin
                    if (req_valid) begin
                        up_reg <= req.up;
                        left_reg <= req.steps;
                        save_reg <= req.save;
                        if (req.steps == 7'h00 && !req.save) begin
                            // Selecting would cost either a step or a save, so stay out
                            cnt_reg <= cyc(NOSAVE_DESELECT_CYC);
                            state_reg <= ST_GUARD;
                        end else begin
                            cnt_reg <= cyc(DIR_SETUP_CYC > SEL_SETUP_CYC ?
                                DIR_SETUP_CYC : SEL_SETUP_CYC);
                            state_reg <= ST_SETUP;
                        end
                    end
                end
                ST_SETUP: begin
                    if (cnt_reg != '0) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else if (left_reg == 7'h00) begin
                        // Save with no steps: select, then release with step high
                        cnt_reg <= cyc(STEP_TO_DESEL_CYC);
                        state_reg <= ST_PRE;
                    end else begin
                        cnt_reg <= cyc(STEP_LOW_CYC);
                        state_reg <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (cnt_reg != '0) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else if (left_reg == 7'h01 && !save_reg) begin
                        // Last step of a no-save frame: step stays low through the release
                        left_reg <= 7'h00;
                        cnt_reg <= cyc(STEP_TO_DESEL_CYC);
                        state_reg <= ST_PRE;
                    end else begin
                        left_reg <= left_reg - 1'b1;
                        cnt_reg <= cyc(STEP_HIGH_CYC > DIR_HOLD_CYC ?
                            STEP_HIGH_CYC : DIR_HOLD_CYC);
                        state_reg <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (cnt_reg != '0) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else if (left_reg != 7'h00) begin
                        cnt_reg <= cyc(STEP_LOW_CYC);
                        state_reg <= ST_LOW;
                    end else begin
                        // Step is already inactive; keep select for the release gap
                        cnt_reg <= cyc(STEP_TO_DESEL_CYC);
                        state_reg <= ST_PRE;
                    end
                end
                ST_PRE: begin
                    if (cnt_reg != '0) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else begin
                        state_reg <= ST_DESEL;
                    end
                end
                ST_DESEL: begin
                    // Guard length depends on whether this release stored the tap
                    cnt_reg <= save_reg ? cyc(SAVE_DESELECT_CYC) :
                        cyc(NOSAVE_DESELECT_CYC);
                    state_reg <= ST_GUARD;
                end
                ST_GUARD: begin
                    // A reset here cuts the save guard short while the device may be writing
                    if (cnt_reg != '0) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pins toward the device
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            // Idle levels from reset on, so no stray step or save reaches the device
            pins.select_n <= 1'b1;
            pins.step_n <= 1'b1;
            pins.up_dn <= 1'b0;
        end else begin
            // Select low only between setup and release, so no step fall lands deselected
            pins.select_n <= !(state_reg == ST_SETUP || state_reg == ST_LOW ||
                state_reg == ST_HIGH || state_reg == ST_PRE);
            if (state_reg == ST_IDLE && req_valid) begin
                pins.up_dn <= req.up;
            end
            // Save: step high at deselect. No save: the last step's low is held
            // across the release, since a fall inside the frame would add a step.
            if (state_reg == ST_LOW) begin
                pins.step_n <= 1'b0;
            end else if (!save_reg && tail_hold(state_reg, cnt_reg)) begin
                pins.step_n <= pins.step_n;
            end else begin
                pins.step_n <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Position model
    // ------------------------------------------------------------
    // The device cannot be read back, so pos is only a model of its counter;
    // the user preloads it when the recalled tap is known.
    always_ff @(posedge clk) begin
        if (rst) begin
            pos <= 7'h00;
        end else if (start_load && state_reg != ST_LOW) begin
            pos <= (start_pos > TAP_MAX) ? TAP_MAX : start_pos;
        end else if (state_reg == ST_LOW && cnt_reg == cyc(STEP_LOW_CYC)) begin
            if (up_reg && pos != TAP_MAX) begin
                pos <= pos + 7'h01;
            end else if (!up_reg && pos != 7'h00) begin
                pos <= pos - 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------
    // Busy has a flop of its own so that both outputs come straight from registers
    always_ff @(posedge clk) begin
        if (rst) begin
            req_ready <= 1'b0;
            busy <= 1'b1;
        end else begin
            req_ready <= is_done(state_reg, cnt_reg, req_valid);
            busy <= !is_done(state_reg, cnt_reg, req_valid);
        end
    end
endmodule

// ---- shared/udwcs_pkg.sv ----
// Purpose: Constants and types for the wiper step host controller
// Assumes: 100 MHz clock, period 10 ns
// Notes: Pin timings are least times, rounded up to whole cycles
package udwcs_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TAP_COUNT = 100;
    localparam logic [6:0] TAP_MAX = 7'h63;
    // Pin timing minima in their own units
    localparam int unsigned SEL_SETUP_NS = 50;
    localparam int unsigned DIR_HOLD_NS = 100;
    localparam int unsigned DIR_SETUP_US = 1;
    localparam int unsigned STEP_LOW_NS = 960;
    localparam int unsigned STEP_HIGH_NS = 960;
    localparam int unsigned STEP_TO_DESEL_US = 1;
    localparam int unsigned NOSAVE_DESELECT_NS = 100;
    localparam int unsigned SAVE_DESELECT_MS = 10;
    localparam int unsigned POWERUP_US = 5;
    function automatic int unsigned ns_cycles(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int unsigned SEL_SETUP_CYC = ns_cycles(SEL_SETUP_NS);
    localparam int unsigned DIR_HOLD_CYC = ns_cycles(DIR_HOLD_NS);
    localparam int unsigned DIR_SETUP_CYC = ns_cycles(DIR_SETUP_US * 1000);
    localparam int unsigned STEP_LOW_CYC = ns_cycles(STEP_LOW_NS);
    localparam int unsigned STEP_HIGH_CYC = ns_cycles(STEP_HIGH_NS);
    localparam int unsigned STEP_TO_DESEL_CYC = ns_cycles(STEP_TO_DESEL_US * 1000);
    localparam int unsigned NOSAVE_DESELECT_CYC = ns_cycles(NOSAVE_DESELECT_NS);
    localparam int unsigned SAVE_DESELECT_CYC = ns_cycles(SAVE_DESELECT_MS * 1000000);
    localparam int unsigned POWERUP_CYC = ns_cycles(POWERUP_US * 1000);
    localparam int unsigned CNT_W = 20;
    // Request from user logic
    typedef struct packed {
        logic       up;
        logic [6:0] steps;
        logic       save;
    } udwcs_req_t;
    // Pins toward the device
    typedef struct packed {
        logic select_n;
        logic step_n;
        logic up_dn;
    } udwcs_pins_t;
    typedef enum logic [2:0] {
        ST_WAKE   = 3'b000,
        ST_IDLE   = 3'b001,
        ST_SETUP  = 3'b010,
        ST_LOW    = 3'b011,
        ST_HIGH   = 3'b100,
        ST_PRE    = 3'b101,
        ST_DESEL  = 3'b110,
        ST_GUARD  = 3'b111
    } udwcs_state_t;
endpackage

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for udwcs_host
// Assumes: Device model answers on the pins
// Notes: Save guard is not waited out; reset ends it
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import udwcs_pkg::*;
    typedef struct packed {logic up; logic [6:0] steps; logic [6:0] exp;} udwcs_row_t;
    logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, start_load = 1'b0, power_up = 1'b0;
    logic req_ready, busy;
    logic [6:0] start_pos = 7'h05, pos, tap, saved;
    logic [99:0] sw;
    udwcs_req_t req = '0;
    udwcs_pins_t pins;
    int failures = 0, samples_checked = 0;
    udwcs_row_t rows [6] = '{'{1'b1, 7'h03, 7'h08}, '{1'b0, 7'h02, 7'h06},
        '{1'b0, 7'h0a, 7'h00}, '{1'b1, 7'h00, 7'h00}, '{1'b1, 7'h64, 7'h63},
        '{1'b0, 7'h01, 7'h62}};
    always #5 clk = ~clk;
    udwcs_host u_udwcs_host (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
        .start_pos(start_pos), .start_load(start_load), .req_ready(req_ready),
        .busy(busy), .pos(pos), .pins(pins));
    udwcs_dev_model u_udwcs_dev_model (.select_n(pins.select_n), .step_n(pins.step_n),
        .up_dn(pins.up_dn), .power_up(power_up), .tap(tap), .saved(saved), .sw(sw));
    task check(input logic [99:0] seen, input logic [99:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task wait_for(input logic v);
        int n;
        n = 0;
        while (req_ready !== v && n < 30000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 30000) failures++;
    endtask
    task send(input logic up, input logic [6:0] steps, input logic save);
        wait_for(1'b1);
        req_valid = 1'b1;
        req = '{up, steps, save};
        @(negedge clk);
        req_valid = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task load(input logic [6:0] v);
        start_pos = v;
        start_load = 1'b1;
        @(negedge clk);
        start_load = 1'b0;
    endtask
    initial begin
        #1ms;
        failures++;
        summarize;
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        wait_for(1'b1);
        load(7'h05);
        foreach (rows[i]) begin
            send(rows[i].up, rows[i].steps, 1'b0);
            wait_for(1'b1);
            check(pos, rows[i].exp);
            check(tap, rows[i].exp);
            check(sw, 100'h1 << rows[i].exp);
        end
        check(saved, 7'h05);
        // A request made while busy must be dropped, not queued
        send(1'b0, 7'h02, 1'b0);
        req_valid = 1'b1;
        req = '{1'b1, 7'h05, 1'b0};
        repeat (20) @(negedge clk);
        req_valid = 1'b0;
        wait_for(1'b1);
        check(tap, 7'h60);
        send(1'b1, 7'h00, 1'b1);
        wait_for(1'b0);
        repeat (400) @(negedge clk);
        check(saved, 7'h60);
        check(busy, 1'b1);
        rst = 1'b1;
        repeat (20) @(negedge clk);
        check(pins, 3'h6);
        rst = 1'b0;
        power_up = 1'b1;
        wait_for(1'b1);
        check(tap, 7'h60);
        load(7'h7f);
        check(pos, 7'h63);
        load(7'h60);
        send(1'b1, 7'h01, 1'b0);
        wait_for(1'b1);
        check(pos, 7'h61);
        check(tap, 7'h61);
        summarize;
    end
endmodule

// ---- verification/udwcs_dev_model.sv ----
// Purpose: Behavioural stepped wiper device
// Assumes: Pins come straight from the host
// Notes: Save completes at once; power_up recalls
module udwcs_dev_model #(parameter logic [6:0] RECALL = 7'h05) (
    input wire logic select_n,
    input wire logic step_n,
    input wire logic up_dn,
    input wire logic power_up,
    output logic [6:0] tap,
    output logic [6:0] saved,
    output logic [99:0] sw
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        saved = RECALL;
        tap = RECALL;
    end
    always @(posedge power_up) tap = saved;
    always @(negedge step_n) begin
        if (!select_n) begin
            if (up_dn) tap = (tap == 7'h63) ? tap : tap + 7'h01;
            else tap = (tap == 7'h00) ? tap : tap - 7'h01;
        end
    end
    always @(posedge select_n) if (step_n) saved = tap;
    assign sw = 100'h1 << tap;
endmodule

// ---- verification/udwcs_host_assertions.sv ----
// Purpose: Pin timing and position checks for udwcs_host
// Assumes: Sees only the top ports
// Notes: Bind follows the module
module udwcs_host_assertions
    import udwcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start_load,
    input wire logic req_ready,
    input wire logic busy,
    input wire logic [6:0] pos,
    input wire udwcs_pkg::udwcs_pins_t pins
);
    logic [7:0] hi_cnt;
    // Saturates so a long idle never wraps to a small value
    always_ff @(posedge clk) begin
        if (rst || !pins.step_n) hi_cnt <= 8'h00;
        else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_low_hold;
        !pins.step_n [*8];
    endsequence
    sequence s_desel_hold;
        pins.select_n [*8];
    endsequence
    a_busy_inverse: assert property (busy == !req_ready) else $error("busy not inverse");
    a_reset_pins_idle: assert property ($fell(rst) |-> pins.select_n && pins.step_n)
        else $error("pins not idle after reset");
    a_step_needs_sel: assert property ($fell(pins.step_n) |-> !pins.select_n)
        else $error("step while deselected");
    a_low_width: assert property ($fell(pins.step_n) |=> s_low_hold)
        else $error("step low too short");
    a_dir_stable: assert property (!pins.select_n && !$past(pins.select_n) |-> $stable(pins.up_dn))
        else $error("direction changed while selected");
    a_release_gap: assert property ($rose(pins.select_n) && pins.step_n |-> hi_cnt >= 8'h64)
        else $error("select released too soon");
    a_desel_hold: assert property ($rose(pins.select_n) |=> s_desel_hold)
        else $error("deselect too short");
    a_pos_bound: assert property (pos <= TAP_MAX) else $error("pos beyond top");
    a_pos_step: assert property ($changed(pos) && !$past(start_load) |->
        !pins.step_n && pos == (pins.up_dn ? $past(pos) + 7'h01 : $past(pos) - 7'h01))
        else $error("pos moved wrongly");
endmodule
bind udwcs_host udwcs_host_assertions u_udwcs_host_assertions (.clk(clk), .rst(rst),
    .start_load(start_load), .req_ready(req_ready), .busy(busy), .pos(pos), .pins(pins));
